// *** src/exec_defs.svh ***
// Constants for the subtract, swap and exclusive-OR execution slice.
// Assumes inclusion by the package and the datapath module only.
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH

// ----------------------------------------
// Widths, operand codes and reset values
// ----------------------------------------
`define DATA_W 8
`define DIR_SEL_A 8'h05
`define DIR_SEL_B 8'h06
`define DIR_SEL_C 8'h07
`define ACC_RESET 8'h00
`define DIR_RESET 8'hff

`endif

// *** src/exec_pkg.sv ***
// Types for the subtract, swap and exclusive-OR execution slice.
// Assumes the constants header sits beside it.
`include "exec_defs.svh"

package exec_pkg;

	// ----------------------------------------
	// Operation selector
	// ----------------------------------------
	typedef enum logic [2:0] {
		OP_NONE,
		OP_SUB,
		OP_SUB_BORROW,
		OP_SWAP,
		OP_XOR_IMM,
		OP_XOR_REG,
		OP_LOAD_DIR
	} exec_op_t;

	// Status flags of the core
	typedef struct packed {
		logic zero;
		logic half_carry_flag;
		logic carry;
	} status_t;

	// One issued instruction
	typedef struct packed {
		exec_op_t op;
		logic dest;
		logic [`DATA_W-1:0] operand;
	} exec_req_t;

	// Write-back towards the file register
	typedef struct packed {
		logic we;
		logic [`DATA_W-1:0] data;
	} file_wr_t;

endpackage : exec_pkg

// *** src/exec_slice.sv ***
// Execution datapath for subtract, nibble swap, exclusive-OR and direction
// load. Assumes the core presents one instruction per clock on req_i with
// the file operand already fetched; status is written back each cycle.
//
// Notes on behaviour
// RULE1: Register minus accumulator, routed by destination bit
// RULE2: Carry and half carry mean no borrow
// RULE3: Borrow subtract uses inverted carry as borrow
// RULE4: Swap nibbles, flags untouched
// RULE5: Immediate XOR into accumulator, zero only
// RULE6: Register XOR routed by destination, zero only
// RULE7: Direction load for operands five to seven
// RULE8: Zero flag set when result is zero
`timescale 1ns/1ps
`include "exec_defs.svh"

module exec_slice (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire exec_pkg::exec_req_t req_i,
	output logic [`DATA_W-1:0] acc_o,
	output exec_pkg::status_t status_o,
	output exec_pkg::file_wr_t file_wr_o,
	output logic [`DATA_W-1:0] port_a_direction_o,
	output logic [`DATA_W-1:0] port_b_direction_o,
	output logic [`DATA_W-1:0] port_c_direction_o
);
	import exec_pkg::*;

	logic [`DATA_W-1:0] acc_r;
	logic [`DATA_W-1:0] acc_nxt;
	status_t status_r;
	status_t status_nxt;
	file_wr_t file_wr_r;
	file_wr_t file_wr_nxt;
	logic [`DATA_W-1:0] dir_a_r;
	logic [`DATA_W-1:0] dir_b_r;
	logic [`DATA_W-1:0] dir_c_r;
	logic [`DATA_W-1:0] result;
	logic [`DATA_W:0] diff;
	logic [4:0] low_diff;
	logic borrow_in;

	// ----------------------------------------
	// Arithmetic
	// ----------------------------------------

	// Zero test shared by every zero flag update
	function automatic logic is_zero(input logic [`DATA_W-1:0] v);
		is_zero = (v == '0);
	endfunction : is_zero

	// Subtract as f + ~W + 1 - borrow; top bit is carry
	always_comb begin
		borrow_in = (req_i.op == OP_SUB_BORROW) ? ~status_r.carry : 1'b0; // RULE3
		diff = {1'b0, req_i.operand} + {1'b0, ~acc_r}
			+ {8'h00, ~borrow_in}; // RULE1
		low_diff = {1'b0, req_i.operand[3:0]} + {1'b0, ~acc_r[3:0]}
			+ {4'h0, ~borrow_in};
	end

	// Result selection per operation
	always_comb begin
		unique case (req_i.op)
			OP_SUB, OP_SUB_BORROW: result = diff[`DATA_W-1:0];
			OP_SWAP: result = {req_i.operand[3:0], req_i.operand[7:4]}; // RULE4
			OP_XOR_IMM, OP_XOR_REG: result = acc_r ^ req_i.operand; // RULE5 RULE6
			default: result = acc_r;
		endcase
	end

	// Next accumulator, write-back and status
	always_comb begin
		acc_nxt = acc_r;
		status_nxt = status_r;
		file_wr_nxt = '{we: 1'b0, data: result};
		unique case (req_i.op)
			OP_SUB, OP_SUB_BORROW: begin
				status_nxt.carry = diff[`DATA_W]; // RULE2
				status_nxt.half_carry_flag = low_diff[4]; // RULE2
				status_nxt.zero = is_zero(result); // RULE8
				if (req_i.dest) file_wr_nxt.we = 1'b1; // RULE1 RULE3
				else acc_nxt = result;
			end
			OP_SWAP: begin
				if (req_i.dest) file_wr_nxt.we = 1'b1; // RULE4
				else acc_nxt = result;
			end
			OP_XOR_IMM: begin
				acc_nxt = result; // RULE5
				status_nxt.zero = is_zero(result); // RULE8
			end
			OP_XOR_REG: begin
				status_nxt.zero = is_zero(result); // RULE8
				if (req_i.dest) file_wr_nxt.we = 1'b1; // RULE6
				else acc_nxt = result;
			end
			default: begin
			end
		endcase
	end

	// ----------------------------------------
	// State
	// ----------------------------------------

	// Accumulator, flags and write-back port
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			acc_r <= `ACC_RESET;
			status_r <= '0;
			file_wr_r <= '0;
		end else begin
			acc_r <= acc_nxt;
			status_r <= status_nxt;
			file_wr_r <= file_wr_nxt;
		end
	end

	// Port direction registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dir_a_r <= `DIR_RESET;
			dir_b_r <= `DIR_RESET;
			dir_c_r <= `DIR_RESET;
		end else if (req_i.op == OP_LOAD_DIR) begin
			if (req_i.operand == `DIR_SEL_A) dir_a_r <= acc_r; // RULE7
			if (req_i.operand == `DIR_SEL_B) dir_b_r <= acc_r; // RULE7
			if (req_i.operand == `DIR_SEL_C) dir_c_r <= acc_r; // RULE7
		end
	end

	// Registered outputs
	assign acc_o = acc_r;
	assign status_o = status_r;
	assign file_wr_o = file_wr_r;
	assign port_a_direction_o = dir_a_r;
	assign port_b_direction_o = dir_b_r;
	assign port_c_direction_o = dir_c_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------

	a_sub_result: assert property ( // RULE1
		@(posedge clk_i) disable iff (!rst_n_i)
		req_i.op == OP_SUB && !req_i.dest |=> acc_o ==
		$past(req_i.operand) - $past(acc_o))
		else $error("subtract result wrong");

	a_write_route: assert property ( // RULE1
		@(posedge clk_i) disable iff (!rst_n_i)
		file_wr_o.we == ($past(req_i.dest) && $past(req_i.op) inside
		{OP_SUB, OP_SUB_BORROW, OP_SWAP, OP_XOR_REG}))
		else $error("file write strobe wrong");

	a_sub_carry: assert property ( // RULE2
		@(posedge clk_i) disable iff (!rst_n_i)
		req_i.op == OP_SUB |=> status_o.carry ==
		($past(acc_o) <= $past(req_i.operand)))
		else $error("subtract carry wrong");

	a_sub_halfcarry: assert property ( // RULE2
		@(posedge clk_i) disable iff (!rst_n_i)
		req_i.op == OP_SUB |=> status_o.half_carry_flag ==
		($past(acc_o[3:0]) <= $past(req_i.operand[3:0])))
		else $error("subtract half carry wrong");

	a_borrow_result: assert property ( // RULE3
		@(posedge clk_i) disable iff (!rst_n_i)
		req_i.op == OP_SUB_BORROW && req_i.dest |=> file_wr_o.we &&
		file_wr_o.data == $past(req_i.operand) - $past(acc_o)
		- {7'h00, ~$past(status_o.carry)})
		else $error("borrow subtract wrong");

	// No borrow out when W plus borrow in still fits in f
	a_borrow_flags: assert property ( // RULE3
		@(posedge clk_i) disable iff (!rst_n_i)
		req_i.op == OP_SUB_BORROW |=>
		status_o.carry == ({1'b0, $past(req_i.operand)} >=
		{1'b0, $past(acc_o)} + {8'h00, ~$past(status_o.carry)}) &&
		status_o.half_carry_flag == ({1'b0, $past(req_i.operand[3:0])} >=
		{1'b0, $past(acc_o[3:0])} + {4'h0, ~$past(status_o.carry)}))
		else $error("borrow subtract flags wrong");

	a_swap_flags: assert property ( // RULE4
		@(posedge clk_i) disable iff (!rst_n_i)
		req_i.op == OP_SWAP |=> $stable(status_o) && (file_wr_o.we ?
		file_wr_o.data : acc_o) == {$past(req_i.operand[3:0]),
		$past(req_i.operand[7:4])})
		else $error("swap wrong");

	a_xor_imm: assert property ( // RULE5
		@(posedge clk_i) disable iff (!rst_n_i)
		req_i.op == OP_XOR_IMM |=> !file_wr_o.we && status_o.carry ==
		$past(status_o.carry) && acc_o == ($past(acc_o) ^ $past(req_i.operand)))
		else $error("immediate xor wrong");

	a_xor_reg_route: assert property ( // RULE6
		@(posedge clk_i) disable iff (!rst_n_i)
		req_i.op == OP_XOR_REG && req_i.dest |=> file_wr_o.we &&
		$stable(acc_o) && $stable(status_o.half_carry_flag))
		else $error("register xor routing wrong");

	a_xor_reg_data: assert property ( // RULE6
		@(posedge clk_i) disable iff (!rst_n_i)
		req_i.op == OP_XOR_REG |=> (file_wr_o.we ? file_wr_o.data : acc_o)
		== ($past(acc_o) ^ $past(req_i.operand)))
		else $error("register xor result wrong");

	a_dir_load: assert property ( // RULE7
		@(posedge clk_i) disable iff (!rst_n_i)
		req_i.op == OP_LOAD_DIR && req_i.operand == `DIR_SEL_B |=>
		port_b_direction_o == $past(acc_o) && $stable(status_o))
		else $error("direction load wrong");

	a_dir_load_a: assert property ( // RULE7
		@(posedge clk_i) disable iff (!rst_n_i)
		req_i.op == OP_LOAD_DIR && req_i.operand == `DIR_SEL_A |=>
		port_a_direction_o == $past(acc_o) && $stable(port_b_direction_o))
		else $error("direction load a wrong");

	a_dir_load_c: assert property ( // RULE7
		@(posedge clk_i) disable iff (!rst_n_i)
		req_i.op == OP_LOAD_DIR && req_i.operand == `DIR_SEL_C |=>
		port_c_direction_o == $past(acc_o) && $stable(port_a_direction_o))
		else $error("direction load c wrong");

	a_dir_refused: assert property ( // RULE7
		@(posedge clk_i) disable iff (!rst_n_i)
		req_i.op == OP_LOAD_DIR && !(req_i.operand inside {`DIR_SEL_A,
		`DIR_SEL_B, `DIR_SEL_C}) |=> $stable(port_a_direction_o) &&
		$stable(port_b_direction_o) && $stable(port_c_direction_o))
		else $error("refused direction load changed state");

	a_zero_flag: assert property ( // RULE8
		@(posedge clk_i) disable iff (!rst_n_i)
		req_i.op inside {OP_SUB, OP_SUB_BORROW, OP_XOR_REG, OP_XOR_IMM} |=>
		status_o.zero == ((file_wr_o.we ? file_wr_o.data : acc_o) == 8'h00))
		else $error("zero flag wrong");

endmodule : exec_slice

// *** verif/exec_slice_tb.sv ***
// Self-checking bench for the subtract, swap, exclusive-OR slice.
// Assumes the slice package is compiled first; no external model.
`timescale 1ns/1ps

module exec_slice_tb;
	import exec_pkg::*;

	// ----------------------------------------
	// Signals and expected state
	// ----------------------------------------
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	exec_req_t req_i;
	logic [7:0] acc_o, dir_a, dir_b, dir_c;
	status_t status_o;
	file_wr_t file_wr_o;
	logic [7:0] e_acc, e_da, e_db, e_dc;
	status_t e_st;
	int n_fail = 0;
	int samples_checked = 0;

	always #10 clk_i = ~clk_i;

	exec_slice dut_u (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.req_i(req_i),
		.acc_o(acc_o),
		.status_o(status_o),
		.file_wr_o(file_wr_o),
		.port_a_direction_o(dir_a),
		.port_b_direction_o(dir_b),
		.port_c_direction_o(dir_c)
	);

	// ----------------------------------------
	// Compare, verdict, one-instruction driver
	// ----------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic give_verdict;
		$display("checked=%0d failed=%0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict

	// Issue at a falling edge, compare at the next one
	task automatic run(input exec_op_t op, input logic d, input logic [7:0] f);
		logic [7:0] r;
		logic b;
		logic we;
		b = (op == OP_SUB_BORROW) ? ~e_st.carry : 1'b0;
		r = f;
		we = 1'b0;
		req_i = {op, d, f};
		@(negedge clk_i);
		case (op)
			OP_SUB, OP_SUB_BORROW: begin
				r = f - e_acc - {7'h00, b};
				e_st.carry = ({1'b0, f} >= e_acc + b);
				e_st.half_carry_flag = ({1'b0, f[3:0]} >= e_acc[3:0] + b);
			end
			OP_SWAP: r = {f[3:0], f[7:4]};
			OP_XOR_IMM, OP_XOR_REG: r = e_acc ^ f;
			OP_LOAD_DIR: begin
				if (f == 8'h05) e_da = e_acc;
				if (f == 8'h06) e_db = e_acc;
				if (f == 8'h07) e_dc = e_acc;
			end
			default: r = f;
		endcase
		if (op inside {OP_SUB, OP_SUB_BORROW, OP_XOR_IMM, OP_XOR_REG})
			e_st.zero = (r == 8'h00);
		if (op inside {OP_SUB, OP_SUB_BORROW, OP_SWAP, OP_XOR_REG}) begin
			we = d;
			if (!d) e_acc = r;
		end
		if (op == OP_XOR_IMM) e_acc = r;
		check(acc_o, e_acc);
		check({5'h00, status_o}, {5'h00, e_st});
		check({7'h00, file_wr_o.we}, {7'h00, we});
		if (we || op == OP_SWAP) check(file_wr_o.data, r);
		check(dir_a, e_da);
		check(dir_b, e_db);
		check(dir_c, e_dc);
	endtask : run

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		req_i = {OP_NONE, 1'b0, 8'h00};
		e_acc = 8'h00;
		e_st = 3'h0;
		{e_da, e_db, e_dc} = {3{8'hff}};
		repeat (12) @(negedge clk_i);
		rst_n_i = 1'b1;
		run(OP_NONE, 1'b1, 8'h00);
		run(OP_XOR_IMM, 1'b0, 8'h03);
		run(OP_SUB, 1'b0, 8'h10);
		run(OP_XOR_IMM, 1'b0, 8'h0d);
		run(OP_XOR_IMM, 1'b0, 8'h83);
		run(OP_SUB, 1'b1, 8'h83);
		run(OP_SUB, 1'b1, 8'h20);
		run(OP_SUB_BORROW, 1'b0, 8'h90);
		run(OP_SUB_BORROW, 1'b1, 8'h0c);
		run(OP_SUB, 1'b0, 8'h0b);
		run(OP_XOR_IMM, 1'b0, 8'hf3);
		run(OP_SUB, 1'b1, 8'h0b);
		run(OP_SUB_BORROW, 1'b0, 8'h0c);
		run(OP_SWAP, 1'b0, 8'ha5);
		run(OP_SWAP, 1'b1, 8'h3c);
		run(OP_XOR_REG, 1'b1, 8'h5a);
		run(OP_XOR_REG, 1'b0, 8'hff);
		run(OP_LOAD_DIR, 1'b0, 8'h05);
		run(OP_XOR_IMM, 1'b1, 8'h0f);
		run(OP_LOAD_DIR, 1'b0, 8'h06);
		run(OP_XOR_IMM, 1'b0, 8'hff);
		run(OP_LOAD_DIR, 1'b0, 8'h07);
		run(OP_LOAD_DIR, 1'b0, 8'h04);
		run(OP_LOAD_DIR, 1'b0, 8'h08);
		run(OP_NONE, 1'b1, 8'h55);
		run(exec_op_t'(3'h7), 1'b1, 8'h07);
		give_verdict();
	end

	// Cuts a hang short
	initial begin
		#100us;
		n_fail++;
		give_verdict();
	end

endmodule : exec_slice_tb
